// [bench/adapter_model.sv]
`timescale 1ns/10ps
`default_nettype none
module adapter_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic stepPulse,
    input wire logic stepDirLeft,
    input wire logic slip,
    input wire logic stall,
    output logic [2:0] emitter
);
    // ==========================================
    // Head position and emitter pulse width
    logic [1:0] ph; // Phase index, 0 is phase one
    logic [2:0] hold; // Six cycles high so the pin filter accepts it
    wire logic [1:0] adv = slip ? 2'h2 : 2'h1; // Slip skips a phase on purpose
    wire logic [1:0] nph = stepDirLeft ? 2'((ph + 2'h3 - adv) % 3) : 2'((ph + adv) % 3);
    always_ff @(posedge mclk)
        if (reset)
            {ph, hold} <= 5'h0;
        else if (stepPulse && !stall)
            {ph, hold} <= {nph, 3'h6};
        else if (hold != 3'h0)
            hold <= hold - 3'h1;
    // Lines idle low between pulses
    assign emitter = hold != 3'h0 ? 3'h1 << ph : 3'h0;
endmodule
`default_nettype wire

// [bench/motion_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module motion_checker #(
    parameter int unsigned STEP_PERIOD_CYC = 20
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic stepPulse,
    input wire logic stepDirLeft,
    input wire logic irq
);
    // ==========================================
    // Helpers: bus decode and step spacing
    wire logic setup = psel && !penable && ce;
    wire logic mapped = paddr <= 8'h10 && paddr[1:0] == 2'h0;
    wire logic rdErr = psel && penable && pready && !pwrite && paddr == 8'h0c;
    wire logic wrCtrl = psel && penable && pready && pwrite && paddr == 8'h00;
    logic [15:0] stepGap; // Saturates so a long idle never wraps into a false short gap
    // Cycles since the last step pulse
    always_ff @(posedge mclk)
        if (reset || stepPulse)
            stepGap <= 16'h0;
        else if (stepGap != 16'hffff)
            stepGap <= stepGap + 16'h1;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // ==========================================
    // Properties
    property p_ready; setup |=> pready; endproperty
    property p_single; pready |=> !pready; endproperty
    property p_slverr; setup && !mapped |=> pslverr; endproperty
    property p_okay; setup && mapped |=> !pslverr; endproperty
    property p_fmt; rdErr && prdata[31] |-> prdata[23:12] == 12'h005; endproperty
    property p_code;
        rdErr && prdata[31] |->
            prdata[11:0] inside {12'h051, 12'h054, 12'h055, 12'h056, 12'h057, 12'h059, 12'h072};
    endproperty
    property p_step; stepPulse |-> stepGap >= STEP_PERIOD_CYC - 1; endproperty
    property p_stepOne; stepPulse |=> !stepPulse; endproperty
    property p_dir; $changed(stepDirLeft) |-> $past(wrCtrl, 1) || $past(wrCtrl, 2); endproperty
    property p_rst; $fell(reset) |-> !stepPulse && !irq && !pready; endproperty
    a_ready: assert property (p_ready) else $error("no answer after setup");
    a_single: assert property (p_single) else $error("ready longer than one cycle");
    a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
    a_okay: assert property (p_okay) else $error("mapped access refused");
    a_fmt: assert property (p_fmt) else $error("error address fields wrong");
    a_code: assert property (p_code) else $error("unknown error code");
    a_step: assert property (p_step) else $error("step pulses too close");
    a_stepOne: assert property (p_stepOne) else $error("step pulse too long");
    a_dir: assert property (p_dir) else $error("direction moved without write");
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    c_err: cover property (rdErr && prdata[31]);
    c_step: cover property (stepPulse);
    c_irq: cover property ($rose(irq));
endmodule
bind printer_head_motion_checker motion_checker #(.STEP_PERIOD_CYC(STEP_PERIOD_CYC)) u_chk (
    .mclk, .reset, .ce, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .stepPulse, .stepDirLeft, .irq);
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    // ==========================================
    // Stimulus and observed outputs
    logic mclk, reset, ce, psel, penable, pwrite, slip, stall, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, r;
    logic [11:0] ctl; // wireDrive, wireOnN, leftMargin, irqReq2N, statusB
    wire logic [31:0] prdata;
    wire logic pready, pslverr, stepPulse, stepDirLeft, irq;
    wire logic [2:0] emit;
    wire printer_head_motion_checker_pkg::adapter_in_t pins = {emit, ctl};
    int miscompares, n_tests, cyc;
    printer_head_motion_checker #(.TIMEOUT80_CYC(400), .TIMEOUT120_CYC(300),
        .WIRE_MAX_CYC(50), .STEP_PERIOD_CYC(20)) u_dut (.mclk, .reset, .ce, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .adapterIn(pins), .stepPulse,
        .stepDirLeft, .irq);
    adapter_model u_adp (.mclk, .reset, .stepPulse, .stepDirLeft, .slip, .stall, .emitter(emit));
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // ==========================================
    // Bus, compare and closing tasks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        {r, e} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x)
        begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", n, x, g);
        end
    endtask
    function automatic logic [31:0] errw(input logic [11:0] c);
        return {8'h80, printer_head_motion_checker_pkg::SUBDEV_ADDR,
            printer_head_motion_checker_pkg::DEV_ADDR, c};
    endfunction
    task automatic rde(input logic [31:0] x);
        apb(1'b0, 8'h0c, 32'h0);
        chk("error", x, x[31] ? r : {31'h0, r[31]});
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic give_verdict;
        if (miscompares == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hang guard, several times the expected run
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            miscompares++;
            give_verdict();
        end
    end
    // ==========================================
    // Main sequence
    initial
    begin
        {reset, ce, psel, penable, pwrite, paddr, pwdata, slip, stall, cyc} = {3'b110, 44'h0, 32'h0};
        ctl = 12'h100;
        pause(12);
        reset <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("reset value", (i == 4) ? 32'h100 : 32'h0, r & 32'h7fffffff);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk("slverr", 32'h1, {31'h0, e});
        ctl <= 12'h004;
        pause(10);
        ctl <= 12'h100;
        pause(6);
        rde(32'h0);
        ctl <= 12'h000;
        pause(10);
        ctl <= 12'h100;
        pause(6);
        rde(errw(12'h055));
        rde(32'h0);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, 8'h08, 32'h1);
        pause(3);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, 8'h04, 32'h1);
        pause(3);
        chk("irq cleared", 32'h0, {31'h0, irq});
        ctl <= 12'hb00;
        pause(80);
        ctl <= 12'h100;
        pause(6);
        rde(errw(12'h051));
        ctl <= 12'h900;
        pause(80);
        ctl <= 12'h100;
        pause(6);
        rde(errw(12'h054));
        slip <= 1'b1;
        apb(1'b1, 8'h00, 32'h1);
        pause(300);
        slip <= 1'b0;
        pause(60);
        rde(32'h0);
        apb(1'b0, 8'h04, 32'h0);
        chk("speed", 32'h2, r & 32'h2);
        pause(100);
        rde(32'h0);
        slip <= 1'b1;
        pause(25);
        slip <= 1'b0;
        pause(10);
        rde(errw(12'h056));
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h00, 32'h7);
        pause(460);
        rde(32'h0);
        stall <= 1'b1;
        pause(350);
        rde(errw(12'h057));
        pause(400);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h00, 32'h7);
        rde(errw(12'h072));
        give_verdict();
    end
endmodule
`default_nettype wire

// [rtl/emitter_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module emitter_checker (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic active,
    input wire logic dirLeft,
    input wire logic fast,
    input wire logic emitPulse,
    input wire logic [1:0] emitPhase,
    input wire logic motorStep,
    input wire logic [23:0] limit80,
    input wire logic [23:0] limit120,
    output logic seqError,
    output logic timeoutError,
    output logic overspeedError
);
    // ==========================================================
    // Expected phase
    logic [1:0] lastPhase; // Phase of the previous pulse
    logic lastValid; // A previous pulse exists since checking began
    logic [23:0] gapCount; // Cycles since the last pulse
    logic [2:0] perStep; // Pulses within the current motor step
    wire [1:0] expRight = (lastPhase == 2'h3) ? 2'h1 : lastPhase + 2'h1;
    wire [1:0] expLeft = (lastPhase == 2'h1) ? 2'h3 : lastPhase - 2'h1;
    wire [1:0] expected = dirLeft ? expLeft : expRight;
    wire [23:0] limit = fast ? limit120 : limit80;
    wire wrongPhase = active && emitPulse && lastValid && (emitPhase != expected);
    wire gapExpired = active && !emitPulse && (gapCount == limit - 24'h1);
    wire tooMany = active && motorStep && (perStep >= printer_head_motion_checker_pkg::OVERSPEED_MIN);
    wire [2:0] perStepInc = (perStep == 3'h7) ? perStep : perStep + 3'h1;
    // ==========================================================
    // Tracking state; all but lastPhase cleared whenever checking is off
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            lastPhase <= 2'h1;
            lastValid <= 1'b0;
            gapCount <= 24'h0;
            perStep <= 3'h0;
        end
        else if (ce)
        begin
            if (!active)
            begin
                lastValid <= 1'b0;
                gapCount <= 24'h0;
                perStep <= 3'h0;
            end
            else
            begin
                // Resynchronise on every pulse, even a wrong one
                if (emitPulse)
                begin
                    lastPhase <= emitPhase;
                    lastValid <= 1'b1;
                end
                // Restart the window on a pulse or after a timeout
                if (emitPulse || gapExpired)
                    gapCount <= 24'h0;
                else
                    gapCount <= gapCount + 24'h1;
                // A new step opens a fresh pulse count
                if (motorStep)
                    perStep <= {2'h0, emitPulse};
                else if (emitPulse)
                    perStep <= perStepInc;
            end
        end
    end
    // ==========================================================
    // One-cycle error pulses
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            seqError <= 1'b0;
            timeoutError <= 1'b0;
            overspeedError <= 1'b0;
        end
        else if (ce)
        begin
            seqError <= wrongPhase;
            timeoutError <= gapExpired;
            overspeedError <= tooMany;
        end
    end
endmodule
`default_nettype wire

// [rtl/printer_head_motion_checker.sv]
// Summary of operation
// - Long wire drive at left margin posts 051
// - Long wire drive away from margin posts 054
// - Level-two request without cause posts 055
// - Moving right expects phases 1,2,3 cyclically
// - Timely but wrong phase posts 056
// - Missing pulse 150/100 ms posts 057
// - Emitter checks start only at running speed
// - Motor turns only on supplied step pulses
// - Five or more pulses per step: overspeed
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module printer_head_motion_checker #(
    parameter int unsigned TIMEOUT80_CYC = printer_head_motion_checker_pkg::TIMEOUT80_CYC,
    parameter int unsigned TIMEOUT120_CYC = printer_head_motion_checker_pkg::TIMEOUT120_CYC,
    parameter int unsigned WIRE_MAX_CYC = printer_head_motion_checker_pkg::WIRE_MAX_CYC,
    parameter int unsigned STEP_PERIOD_CYC = printer_head_motion_checker_pkg::STEP_PERIOD_CYC
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire printer_head_motion_checker_pkg::adapter_in_t adapterIn,
    output logic stepPulse,
    output logic stepDirLeft,
    output logic irq
);
    // ==========================================================
    // Pin synchronisation
    logic [printer_head_motion_checker_pkg::PINS_W-1:0] pinsFlat; // Filtered pin levels
    printer_head_motion_checker_pkg::adapter_in_t pins; // Same, as fields
    assign pins = pinsFlat;

    sync_filter #(
        .W(printer_head_motion_checker_pkg::PINS_W)
    ) u_sync (
        .mclk(mclk),
        .reset(reset),
        .ce(ce),
        .din(adapterIn),
        .dout(pinsFlat)
    );

    // ==========================================================
    // Registers
    logic [2:0] ctrl; // Run, speed and direction
    logic [2:0] status; // Sticky events
    logic [2:0] mask; // Interrupt enables
    printer_head_motion_checker_pkg::err_rec_t errRec; // Posted error
    printer_head_motion_checker_pkg::motor_state_t motorState; // Stepper phase
    logic [23:0] stepCount; // Cycles within one step period
    logic [4:0] accelSteps; // Steps taken while accelerating
    logic [23:0] wireCount; // Cycles the wire driver has been on
    logic wireFlagged; // One report per over-long drive
    logic [2:0] prevEmit; // Emitter levels one cycle ago
    logic prevIrq; // Request level one cycle ago

    // ==========================================================
    // APB decode
    wire setup = psel && !penable;
    wire access = psel && penable && pready;
    wire wrDone = access && pwrite;
    wire hitCtrl = (paddr == printer_head_motion_checker_pkg::OFF_CTRL);
    wire hitStatus = (paddr == printer_head_motion_checker_pkg::OFF_STATUS);
    wire hitMask = (paddr == printer_head_motion_checker_pkg::OFF_MASK);
    wire hitError = (paddr == printer_head_motion_checker_pkg::OFF_ERROR);
    wire hitPins = (paddr == printer_head_motion_checker_pkg::OFF_PINS);
    wire mapped = hitCtrl || hitStatus || hitMask || hitError || hitPins;
    // Read of the error word releases it
    wire readErr = access && !pwrite && hitError;
    wire wrCtrl = wrDone && hitCtrl;
    wire wrStatus = wrDone && hitStatus;
    wire wrMask = wrDone && hitMask;
    wire [31:0] readMux =
        hitCtrl ? {29'h0, ctrl} :
        hitStatus ? {29'h0, status} :
        hitMask ? {29'h0, mask} :
        hitError ? errRec :
        hitPins ? {17'h0, pins} : 32'h0;

    // ==========================================================
    // Control bits
    wire runBit = ctrl[printer_head_motion_checker_pkg::CTRL_RUN];
    wire fastBit = ctrl[printer_head_motion_checker_pkg::CTRL_FAST];
    wire leftBit = ctrl[printer_head_motion_checker_pkg::CTRL_LEFT];
    // A new operation is a write that turns run on
    wire opStart = wrCtrl && !runBit && pwdata[printer_head_motion_checker_pkg::CTRL_RUN];

    // ==========================================================
    // Stepper drive
    wire [23:0] stepLast = STEP_PERIOD_CYC[23:0] - 24'h1;
    wire [23:0] wireLast = WIRE_MAX_CYC[23:0] - 24'h1;
    wire motorOn = (motorState != printer_head_motion_checker_pkg::M_IDLE);
    wire stepTick = motorOn && (stepCount == stepLast);
    wire accelDone = stepTick &&
        (accelSteps == printer_head_motion_checker_pkg::ACCEL_STEPS - 5'h1);
    wire checking = (motorState == printer_head_motion_checker_pkg::M_RUN);
    wire reachedSpeed = (motorState == printer_head_motion_checker_pkg::M_ACCEL) && accelDone;
    logic [1:0] next_motorState;

    // Motor phase sequencing
    always_comb
    begin
        next_motorState = motorState;
        case (motorState)
            printer_head_motion_checker_pkg::M_IDLE:
                if (runBit)
                    next_motorState = printer_head_motion_checker_pkg::M_ACCEL;
            printer_head_motion_checker_pkg::M_ACCEL:
                // Dropping run stops the motor at once
                if (!runBit)
                    next_motorState = printer_head_motion_checker_pkg::M_IDLE;
                else if (accelDone)
                    next_motorState = printer_head_motion_checker_pkg::M_RUN;
            printer_head_motion_checker_pkg::M_RUN:
                if (!runBit)
                    next_motorState = printer_head_motion_checker_pkg::M_IDLE;
            default:
                next_motorState = printer_head_motion_checker_pkg::M_IDLE;
        endcase
    end

    // Step period and acceleration counters
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            motorState <= printer_head_motion_checker_pkg::M_IDLE;
            stepCount <= 24'h0;
            accelSteps <= 5'h0;
        end
        else if (ce)
        begin
            motorState <= printer_head_motion_checker_pkg::motor_state_t'(next_motorState);
            if (!motorOn || stepTick)
                stepCount <= 24'h0;
            else
                stepCount <= stepCount + 24'h1;
            if (!motorOn)
                accelSteps <= 5'h0;
            else if (stepTick && !accelDone)
                accelSteps <= accelSteps + 5'h1;
        end
    end

    // Step outputs to the head motor
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            stepPulse <= 1'b0;
            stepDirLeft <= 1'b0;
        end
        else if (ce)
        begin
            stepPulse <= stepTick;
            stepDirLeft <= leftBit;
        end
    end

    // ==========================================================
    // Emitter edges and phase
    wire [2:0] emitRise = pins.emitter & ~prevEmit;
    wire emitPulse = |emitRise;
    wire [1:0] emitPhase = emitRise[0] ? 2'h1 : (emitRise[1] ? 2'h2 : 2'h3);
    logic seqError;
    logic timeoutError;
    logic overspeedError;

    emitter_checker u_emit (
        .mclk(mclk),
        .reset(reset),
        .ce(ce),
        .active(checking),
        .dirLeft(leftBit),
        .fast(fastBit),
        .emitPulse(emitPulse),
        .emitPhase(emitPhase),
        .motorStep(stepTick),
        .limit80(TIMEOUT80_CYC[23:0]),
        .limit120(TIMEOUT120_CYC[23:0]),
        .seqError(seqError),
        .timeoutError(timeoutError),
        .overspeedError(overspeedError)
    );

    // ==========================================================
    // Wire drive and interrupt cause checks
    wire wireLineOn = !pins.wireOnN;
    wire wireExpired = pins.wireDrive && !wireFlagged && (wireCount == wireLast);
    wire wireErrLeft = wireExpired && wireLineOn && pins.leftMargin;
    wire wireErrAway = wireExpired && wireLineOn && !pins.leftMargin;
    wire irqActive = !pins.irqReq2N;
    wire noCause = !(pins.statusB[printer_head_motion_checker_pkg::SB_EMIT] ||
        pins.statusB[printer_head_motion_checker_pkg::SB_NOTRDY] ||
        pins.statusB[printer_head_motion_checker_pkg::SB_FORMS] ||
        pins.statusB[printer_head_motion_checker_pkg::SB_TIMER]);
    wire undefIrq = irqActive && !prevIrq && noCause;

    // Drive timer and edge history
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            wireCount <= 24'h0;
            wireFlagged <= 1'b0;
            prevEmit <= 3'h0;
            // Filter output starts low: count the request as seen, so no false edge
            prevIrq <= 1'b1;
        end
        else if (ce)
        begin
            // Timer runs only while a driver is on
            if (!pins.wireDrive)
                wireCount <= 24'h0;
            else if (wireCount != wireLast)
                wireCount <= wireCount + 24'h1;
            wireFlagged <= pins.wireDrive && (wireFlagged || wireExpired);
            prevEmit <= pins.emitter;
            prevIrq <= irqActive;
        end
    end

    // ==========================================================
    // Error posting; several faults in one cycle keep the lowest code
    wire postAny = wireErrLeft || wireErrAway || undefIrq || seqError ||
        timeoutError || overspeedError;
    wire [11:0] postCode =
        wireErrLeft ? printer_head_motion_checker_pkg::ERR_WIRE_LEFT :
        wireErrAway ? printer_head_motion_checker_pkg::ERR_WIRE_AWAY :
        undefIrq ? printer_head_motion_checker_pkg::ERR_UNDEF_IRQ :
        seqError ? printer_head_motion_checker_pkg::ERR_SEQUENCE :
        timeoutError ? printer_head_motion_checker_pkg::ERR_MISSING :
        printer_head_motion_checker_pkg::ERR_OVERSPEED;
    // A fault in the cycle of the releasing read still lands
    wire loadNew = postAny && (!errRec.valid || readErr);
    wire loadNoSense = opStart && errRec.valid && !readErr;
    wire [11:0] loadCode = loadNew ? postCode : printer_head_motion_checker_pkg::ERR_NO_SENSE;

    // Error record
    always_ff @(posedge mclk)
    begin
        if (reset)
            errRec <= '0;
        else if (ce)
        begin
            if (loadNew || loadNoSense)
            begin
                errRec.valid <= 1'b1;
                errRec.pad <= 7'h0;
                errRec.subdev <= printer_head_motion_checker_pkg::SUBDEV_ADDR;
                errRec.devAddr <= printer_head_motion_checker_pkg::DEV_ADDR;
                errRec.code <= loadCode;
            end
            else if (readErr)
                errRec.valid <= 1'b0;
        end
    end

    // ==========================================================
    // Sticky status, mask and control
    wire [2:0] events = {checking && emitPulse, reachedSpeed, loadNew || loadNoSense};
    wire [2:0] w1c = wrStatus ? pwdata[2:0] : 3'h0;
    // Set wins over the write-one clear
    wire [2:0] next_status = (status & ~w1c) | events;

    // Software-visible registers
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            ctrl <= printer_head_motion_checker_pkg::CTRL_RESET;
            status <= printer_head_motion_checker_pkg::STATUS_RESET;
            mask <= printer_head_motion_checker_pkg::MASK_RESET;
        end
        else if (ce)
        begin
            if (wrCtrl)
                ctrl <= pwdata[2:0];
            if (wrMask)
                mask <= pwdata[2:0];
            status <= next_status;
        end
    end

    // ==========================================================
    // APB answer: one wait-free access cycle after setup
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            irq <= 1'b0;
        end
        else if (ce)
        begin
            pready <= setup;
            pslverr <= setup && !mapped;
            // Data is captured at setup; a later state change shows next read
            if (setup)
                prdata <= pwrite ? 32'h0 : readMux;
            irq <= |(status & mask);
        end
    end
endmodule
`default_nettype wire

// [rtl/printer_head_motion_checker_pkg.sv]
`default_nettype none
package printer_head_motion_checker_pkg;
    // ==========================================================
    // Register offsets (byte addresses on the APB bus)
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_ERROR = 8'h0c;
    localparam logic [7:0] OFF_PINS = 8'h10;
    // ==========================================================
    // Control field positions
    localparam int CTRL_RUN = 0;
    localparam int CTRL_FAST = 1;
    localparam int CTRL_LEFT = 2;
    localparam int CTRL_W = 3;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    // ==========================================================
    // Sticky status and mask field positions
    localparam int STS_ERR = 0;
    localparam int STS_SPEED = 1;
    localparam int STS_EMIT = 2;
    localparam int STS_W = 3;
    localparam logic [2:0] STATUS_RESET = 3'h0;
    localparam logic [2:0] MASK_RESET = 3'h0;
    // ==========================================================
    // Adapter status byte B cause bits
    localparam int SB_EMIT = 2;
    localparam int SB_NOTRDY = 3;
    localparam int SB_FORMS = 6;
    localparam int SB_TIMER = 7;
    // ==========================================================
    // Error codes, held as three BCD digits
    localparam logic [11:0] ERR_WIRE_LEFT = 12'h051;
    localparam logic [11:0] ERR_WIRE_AWAY = 12'h054;
    localparam logic [11:0] ERR_UNDEF_IRQ = 12'h055;
    localparam logic [11:0] ERR_SEQUENCE = 12'h056;
    localparam logic [11:0] ERR_MISSING = 12'h057;
    localparam logic [11:0] ERR_OVERSPEED = 12'h059;
    localparam logic [11:0] ERR_NO_SENSE = 12'h072;
    localparam logic [3:0] DEV_ADDR = 4'h5;
    localparam logic [7:0] SUBDEV_ADDR = 8'h00;
    // ==========================================================
    // Timing
    localparam int unsigned CLK_KHZ = 50000;
    localparam int unsigned TIMEOUT80_MS = 150;
    localparam int unsigned TIMEOUT120_MS = 100;
    localparam int unsigned TIMEOUT80_CYC = TIMEOUT80_MS * CLK_KHZ;
    localparam int unsigned TIMEOUT120_CYC = TIMEOUT120_MS * CLK_KHZ;
    localparam int unsigned WIRE_MAX_US = 2000;
    localparam int unsigned WIRE_MAX_CYC = WIRE_MAX_US * CLK_KHZ / 1000;
    localparam int unsigned STEP_PERIOD_US = 1000;
    localparam int unsigned STEP_PERIOD_CYC = STEP_PERIOD_US * CLK_KHZ / 1000;
    localparam logic [4:0] ACCEL_STEPS = 5'h10;
    localparam logic [2:0] OVERSPEED_MIN = 3'h5;
    localparam int CNT_W = 24;
    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [2:0] emitter;
        logic wireDrive;
        logic wireOnN;
        logic leftMargin;
        logic irqReq2N;
        logic [7:0] statusB;
    } adapter_in_t;
    localparam int PINS_W = 15;
    typedef struct packed {
        logic valid;
        logic [6:0] pad;
        logic [7:0] subdev;
        logic [3:0] devAddr;
        logic [11:0] code;
    } err_rec_t;
    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_ACCEL = 2'b01,
        M_RUN = 2'b11
    } motor_state_t;
endpackage
`default_nettype wire

// [rtl/sync_filter.sv]
`timescale 1ns/10ps
`default_nettype none
module sync_filter #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    // ==========================================================
    // Three-stage synchroniser per bit
    // The output moves only once stages two and three agree, so a
    // single-cycle glitch never reaches the checker.
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            logic s1; // Metastable stage, read only by s2
            logic s2;
            logic s3;
            always_ff @(posedge mclk)
            begin
                if (reset)
                begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    dout[i] <= 1'b0;
                end
                else if (ce)
                begin
                    s1 <= din[i];
                    s2 <= s1;
                    s3 <= s2;
                    // Accept only a settled level
                    if (s2 == s3)
                        dout[i] <= s3;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire
